// file: rtl/dual_uart_pkg.sv
// Shared constants, types and register map for the dual serial channel block
package dual_uart_pkg;

    // ------------------------------------------------------------
    // Clock and reference
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int REF_MHZ = 120;
    localparam int INT_W   = 14;
    localparam int FRAC_W  = 4;
    localparam int FRAC_DIV = 16;
    localparam int BUF_AW  = 12;
    localparam int NCH     = 2;
    localparam logic [4:0] OVS_16 = 5'h10;
    localparam logic [4:0] OVS_10 = 5'h0a;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [4:0] OFF_CTRL  = 5'h00;
    localparam logic [4:0] OFF_DIV   = 5'h04;
    localparam logic [4:0] OFF_STAT  = 5'h08;
    localparam logic [4:0] OFF_DATA  = 5'h0c;
    localparam logic [7:0] OFF_ID    = 8'h40;
    localparam logic [7:0] OFF_SYS   = 8'h44;

    // Reset values: 8N1, x16, divisor 781 + 4/16 (9600 baud)
    localparam logic [5:0]        CTRL_RST     = 6'h00;
    localparam logic [INT_W-1:0]  DIV_INT_RST  = 14'h030d;
    localparam logic [FRAC_W-1:0] DIV_FRAC_RST = 4'h4;

    // Arbitrary identification values
    localparam logic [15:0] VENDOR_ID_DEF  = 16'h1d50;
    localparam logic [15:0] PRODUCT_ID_DEF = 16'h0a5a;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_UART = 2'h0,
        MODE_FIFO = 2'h1,
        MODE_OPTO = 2'h2
    } mode_e;

    typedef enum logic [2:0] {
        PAR_NONE  = 3'h0,
        PAR_ODD   = 3'h1,
        PAR_EVEN  = 3'h2,
        PAR_MARK  = 3'h3,
        PAR_SPACE = 3'h4
    } parity_e;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'b000,
        SER_START = 3'b001,
        SER_DATA  = 3'b011,
        SER_PAR   = 3'b010,
        SER_STOP  = 3'b110
    } ser_state_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] parity;
        logic       stop2;
        logic       data7;
        logic       ovs10;
    } ctrl_s;

    typedef struct packed {
        logic       remote_wake;
        logic       soft_pulldown;
        logic [1:0] drive;
        logic [3:0] modes;
    } cfg_s;

    localparam cfg_s CFG_DEFAULT = '{1'b0, 1'b0, 2'h0, 4'h0};

endpackage

// file: rtl/baud_gen.sv
// Fractional baud rate generator producing the oversampling tick
`timescale 1ns/10ps
module baud_gen
    import dual_uart_pkg::*;
#(
    parameter int IW = INT_W,
    parameter int FW = FRAC_W
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // Divisor
    input  wire logic [IW-1:0] i_div_int,
    input  wire logic [FW-1:0] i_div_frac,
    // Oversampling tick
    output logic               o_tick
);
    // ------------------------------------------------------------
    // Reference emulation
    // ------------------------------------------------------------
    // Accumulate in units of 1/(16*CLK_MHZ) reference periods so the
    // 120 MHz reference is modelled exactly from the 125 MHz clock.
    localparam int AW = IW + FW + 8;
    localparam logic [AW-1:0] STEP = AW'(REF_MHZ * FRAC_DIV);

    logic [IW-1:0]    div_eff;
    logic [AW-1:0]    thr;
    logic [AW-1:0]    acc_r;
    logic [AW-1:0]    acc_sum;
    logic             hit;

    // Zero prescaler would tick every clock, so it counts as one
    assign div_eff = (i_div_int == '0) ? IW'(1) : i_div_int;
    assign thr     = AW'({div_eff, i_div_frac}) * AW'(CLK_MHZ);
    assign acc_sum = acc_r + STEP;
    assign hit     = acc_sum >= thr;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r  <= '0;
            o_tick <= 1'b0;
        end else begin
            acc_r  <= hit ? acc_sum - thr : acc_sum;
            o_tick <= hit;
        end
    end
endmodule

// file: rtl/dual_uart_bridge.sv
// Two independent serial channels with buffers, baud generators and bus slave
//
// What this block does
// - Two channels, each with own settings and own baud generator.
// - Oversampling tick from 120 MHz reference, factor sixteen or ten.
// - Divisor is 14-bit integer prescaler plus 4-bit fraction.
// - Serial rate programmable across roughly 458 baud to 12 Mbaud.
// - Each channel has a 4 KB transmit buffer filled by the host.
// - Each channel has a 4 KB receive buffer drained by the host.
// - Driver enable high only while the channel sends a character.
// - Power enable (active low) inactive during reset and suspend, active otherwise.
// - Internal logic resets at power-up and on external low reset.
// - Without configuration both channels are serial ports, built-in IDs, no serial.
// - Valid configuration selects each channel's personality independently.
// - Configuration also sets remote wake, soft pull-down and drive strength.
`timescale 1ns/10ps
module dual_uart_bridge
    import dual_uart_pkg::*;
#(
    parameter int          AW         = BUF_AW,
    parameter logic [15:0] VENDOR_ID  = VENDOR_ID_DEF,
    parameter logic [15:0] PRODUCT_ID = PRODUCT_ID_DEF
) (
    // Clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    // Wishbone slave
    input  wire logic           i_wb_cyc,
    input  wire logic           i_wb_stb,
    input  wire logic           i_wb_we,
    input  wire logic [7:0]     i_wb_adr,
    input  wire logic [3:0]     i_wb_sel,
    input  wire logic [31:0]    i_wb_dat,
    output logic      [31:0]    o_wb_dat,
    output logic                o_wb_ack,
    // Serial lines
    input  wire logic [NCH-1:0] i_rxd,
    output logic      [NCH-1:0] o_txd,
    output logic      [NCH-1:0] o_transmit_driver_enable,
    // Power
    input  wire logic           i_suspend,
    output logic                o_power_enable_n,
    // Configuration memory
    input  wire logic           i_cfg_valid,
    input  wire cfg_s           i_cfg,
    output cfg_s                o_cfg
);
    localparam int DEPTH = 1 << AW;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Configuration capture and power
    // ------------------------------------------------------------
    logic cfg_done_r;
    logic serial_present_r;

    // defaults / adopted once after reset release
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_done_r       <= 1'b0;
            o_cfg            <= CFG_DEFAULT;
            serial_present_r <= 1'b0;
        end else if (!cfg_done_r) begin
            cfg_done_r       <= 1'b1;
            o_cfg            <= i_cfg_valid ? i_cfg : CFG_DEFAULT;
            serial_present_r <= i_cfg_valid;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_power_enable_n <= 1'b1;
        end else begin
            o_power_enable_n <= i_suspend;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    logic             wb_hit;
    logic             wb_wr;
    logic             wb_rd;
    logic             in_ch;
    logic [4:0]       ch_off;
    logic [31:0]      ch_rd [NCH];
    logic [31:0]      rd_mux;

    assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wb_wr  = wb_hit & i_wb_we;
    assign wb_rd  = wb_hit & ~i_wb_we;
    assign in_ch  = (i_wb_adr[7:6] == 2'h0) & ~i_wb_adr[4];
    assign ch_off = i_wb_adr[4:0];
    assign rd_mux = in_ch ? ch_rd[i_wb_adr[5]]
                  : (i_wb_adr == OFF_ID) ? {VENDOR_ID, PRODUCT_ID}
                  : (i_wb_adr == OFF_SYS) ? {22'h0, o_cfg, serial_present_r,
                                             ~o_power_enable_n}
                  : 32'h0;

    // One wait state; unmapped addresses answer zero
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_hit;
            o_wb_dat <= wb_rd ? rd_mux : o_wb_dat;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // independent channels
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        ctrl_s              ctrl_r;
        logic [INT_W-1:0]   div_int_r;
        logic [FRAC_W-1:0]  div_frac_r;
        logic               tick;
        logic [7:0]         txm [DEPTH];
        logic [7:0]         rxm [DEPTH];
        logic [AW:0]        tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
        logic [AW:0]        tx_fill, rx_fill;
        logic               sel_ch, wr_ctrl, wr_div, wr_stat, wr_data, rd_data;
        logic               is_uart, tx_avail;
        logic [4:0]         ovs, half;
        logic [2:0]         last_bit;
        logic [7:0]         tx_byte_r, rx_sh_r;
        logic [7:0]         tx_mask;
        logic               tx_par, rx_par;
        ser_state_e         tx_st_r, rx_st_r;
        logic [4:0]         tx_cnt_r, rx_cnt_r;
        logic [2:0]         tx_bit_r, rx_bit_r;
        logic               par_ev_r, frm_ev_r, ovr_ev_r;
        logic               par_err_r, frm_err_r, ovr_err_r;
        logic               tx_end, rx_mid;

        assign sel_ch  = in_ch & (i_wb_adr[5] == 1'(ch));
        assign wr_ctrl = wb_wr & sel_ch & (ch_off == OFF_CTRL);
        assign wr_div  = wb_wr & sel_ch & (ch_off == OFF_DIV);
        assign wr_stat = wb_wr & sel_ch & (ch_off == OFF_STAT) & i_wb_sel[3];
        assign wr_data = wb_wr & sel_ch & (ch_off == OFF_DATA) & i_wb_sel[0];
        assign rd_data = wb_rd & sel_ch & (ch_off == OFF_DATA) & (rx_fill != '0);
        assign tx_fill = tx_wp_r - tx_rp_r;
        assign rx_fill = rx_wp_r - rx_rp_r;
        // only the serial personality runs this engine
        assign is_uart = o_cfg.modes[ch*2 +: 2] == MODE_UART;
        assign tx_avail = is_uart & (tx_fill != '0);
        assign ovs      = ctrl_r.ovs10 ? OVS_10 : OVS_16;
        assign half     = ovs >> 1;
        assign last_bit = ctrl_r.data7 ? 3'h6 : 3'h7;
        assign tx_mask  = ctrl_r.data7 ? 8'h7f : 8'hff;
        assign tx_par   = par_bit(ctrl_r.parity, ^(tx_byte_r & tx_mask));
        assign rx_par   = par_bit(ctrl_r.parity, ^(rx_sh_r & tx_mask));
        assign tx_end   = tick & (tx_cnt_r == ovs - 5'h01);
        assign rx_mid   = tick & (rx_cnt_r == ((rx_st_r == SER_START) ? half : ovs) - 5'h01);

        assign ch_rd[ch] = (ch_off == OFF_CTRL) ? {26'h0, ctrl_r}
                         : (ch_off == OFF_DIV)  ? {14'h0, div_frac_r, div_int_r}
                         : (ch_off == OFF_STAT) ? {is_uart, ~is_uart,
                                                   o_transmit_driver_enable[ch],
                                                   ovr_err_r, frm_err_r, par_err_r,
                                                   13'(tx_fill), 13'(rx_fill)}
                         : (ch_off == OFF_DATA) ? {23'h0, rx_fill != '0,
                                                   rxm[rx_rp_r[AW-1:0]]}
                         : 32'h0;

        // own prescaler and fraction per channel
        baud_gen u_baud (
            .i_clk      (i_clk),
            .i_rst_n    (rst_n),
            .i_div_int  (div_int_r),
            .i_div_frac (div_frac_r),
            .o_tick     (tick)
        );

        // Host side: settings, transmit fill, receive drain
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_r     <= CTRL_RST;
                div_int_r  <= DIV_INT_RST;
                div_frac_r <= DIV_FRAC_RST;
                tx_wp_r    <= '0;
                rx_rp_r    <= '0;
            end else begin
                if (wr_ctrl) begin
                    ctrl_r <= 6'(lane_merge({26'h0, ctrl_r}, i_wb_dat, i_wb_sel));
                end
                if (wr_div) begin
                    {div_frac_r, div_int_r} <= 18'(lane_merge({14'h0, div_frac_r,
                                                  div_int_r}, i_wb_dat, i_wb_sel));
                end
                // full buffer drops the write and flags overrun
                if (wr_data && tx_fill != (AW+1)'(DEPTH)) begin
                    txm[tx_wp_r[AW-1:0]] <= i_wb_dat[7:0];
                    tx_wp_r              <= tx_wp_r + 1'b1;
                end
                if (rd_data) begin
                    rx_rp_r <= rx_rp_r + 1'b1;
                end
            end
        end

        // Sticky errors: a new event outranks a clear in the same cycle
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                par_err_r <= 1'b0;
                frm_err_r <= 1'b0;
                ovr_err_r <= 1'b0;
            end else begin
                par_err_r <= (par_err_r & ~(wr_stat & i_wb_dat[26])) | par_ev_r;
                frm_err_r <= (frm_err_r & ~(wr_stat & i_wb_dat[27])) | frm_ev_r;
                ovr_err_r <= (ovr_err_r & ~(wr_stat & i_wb_dat[28])) | ovr_ev_r;
            end
        end

        // transmit framing / driver enable spans back-to-back bytes
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                tx_st_r   <= SER_IDLE;
                tx_cnt_r  <= 5'h00;
                tx_bit_r  <= 3'h0;
                tx_byte_r <= 8'h00;
                tx_rp_r   <= '0;
                o_txd[ch] <= 1'b1;
                o_transmit_driver_enable[ch] <= 1'b0;
            end else begin
                tx_cnt_r <= tick ? (tx_end ? 5'h00 : tx_cnt_r + 5'h01) : tx_cnt_r;
                case (tx_st_r)
                    SER_IDLE: begin
                        tx_cnt_r <= 5'h00;
                        if (tx_avail) begin
                            tx_st_r   <= SER_START;
                            tx_byte_r <= txm[tx_rp_r[AW-1:0]];
                            tx_rp_r   <= tx_rp_r + 1'b1;
                            o_txd[ch] <= 1'b0;
                            o_transmit_driver_enable[ch] <= 1'b1;
                        end
                    end
                    SER_START: begin
                        if (tx_end) begin
                            tx_st_r   <= SER_DATA;
                            tx_bit_r  <= 3'h0;
                            o_txd[ch] <= tx_byte_r[0];
                        end
                    end
                    SER_DATA: begin
                        if (tx_end && tx_bit_r == last_bit) begin
                            tx_st_r   <= (ctrl_r.parity == PAR_NONE) ? SER_STOP : SER_PAR;
                            o_txd[ch] <= (ctrl_r.parity == PAR_NONE) ? 1'b1 : tx_par;
                            tx_bit_r  <= 3'h0;
                        end else if (tx_end) begin
                            tx_bit_r  <= tx_bit_r + 3'h1;
                            o_txd[ch] <= tx_byte_r[tx_bit_r + 3'h1];
                        end
                    end
                    SER_PAR: begin
                        if (tx_end) begin
                            tx_st_r   <= SER_STOP;
                            o_txd[ch] <= 1'b1;
                        end
                    end
                    SER_STOP: begin
                        if (tx_end && ctrl_r.stop2 && tx_bit_r == 3'h0) begin
                            tx_bit_r <= 3'h1;
                        end else if (tx_end && tx_avail) begin
                            tx_st_r   <= SER_START;
                            tx_byte_r <= txm[tx_rp_r[AW-1:0]];
                            tx_rp_r   <= tx_rp_r + 1'b1;
                            o_txd[ch] <= 1'b0;
                        end else if (tx_end) begin
                            tx_st_r <= SER_IDLE;
                            o_transmit_driver_enable[ch] <= 1'b0;
                        end
                    end
                    default: begin
                        tx_st_r   <= SER_IDLE;
                        o_txd[ch] <= 1'b1;
                        o_transmit_driver_enable[ch] <= 1'b0;
                    end
                endcase
            end
        end

        // receive framing; start bit checked at mid-bit to reject glitches
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                rx_st_r  <= SER_IDLE;
                rx_cnt_r <= 5'h00;
                rx_bit_r <= 3'h0;
                rx_sh_r  <= 8'h00;
                rx_wp_r  <= '0;
                par_ev_r <= 1'b0;
                frm_ev_r <= 1'b0;
                ovr_ev_r <= 1'b0;
            end else begin
                par_ev_r <= 1'b0;
                frm_ev_r <= 1'b0;
                ovr_ev_r <= wr_data & (tx_fill == (AW+1)'(DEPTH));
                rx_cnt_r <= tick ? (rx_mid ? 5'h00 : rx_cnt_r + 5'h01) : rx_cnt_r;
                case (rx_st_r)
                    SER_IDLE: begin
                        rx_cnt_r <= 5'h00;
                        if (is_uart && !i_rxd[ch]) begin
                            rx_st_r <= SER_START;
                        end
                    end
                    SER_START: begin
                        if (rx_mid) begin
                            rx_st_r  <= i_rxd[ch] ? SER_IDLE : SER_DATA;
                            rx_bit_r <= 3'h0;
                            rx_sh_r  <= 8'h00;
                        end
                    end
                    SER_DATA: begin
                        if (rx_mid) begin
                            rx_sh_r[rx_bit_r] <= i_rxd[ch];
                            rx_bit_r          <= rx_bit_r + 3'h1;
                            if (rx_bit_r == last_bit) begin
                                rx_st_r <= (ctrl_r.parity == PAR_NONE) ? SER_STOP : SER_PAR;
                            end
                        end
                    end
                    SER_PAR: begin
                        if (rx_mid) begin
                            rx_st_r  <= SER_STOP;
                            par_ev_r <= i_rxd[ch] != rx_par;
                        end
                    end
                    SER_STOP: begin
                        if (rx_mid) begin
                            rx_st_r  <= SER_IDLE;
                            frm_ev_r <= ~i_rxd[ch];
                            // byte stored unless the buffer is full
                            if (rx_fill != (AW+1)'(DEPTH)) begin
                                rxm[rx_wp_r[AW-1:0]] <= rx_sh_r;
                                rx_wp_r              <= rx_wp_r + 1'b1;
                            end else begin
                                ovr_ev_r <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rx_st_r <= SER_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Parity helper
    // ------------------------------------------------------------
    function automatic logic par_bit(input logic [2:0] mode, input logic xr);
        case (mode)
            PAR_ODD:  par_bit = ~xr;
            PAR_EVEN: par_bit = xr;
            PAR_MARK: par_bit = 1'b1;
            default:  par_bit = 1'b0;
        endcase
    endfunction
endmodule

// file: verif/dual_uart_props.sv
// Port checker for the dual serial channel block
`timescale 1ns/10ps
module dual_uart_props
    import dual_uart_pkg::*;
(
    input wire logic           i_clk,
    input wire logic           i_rstn,
    input wire logic           i_suspend,
    input wire logic           i_cfg_valid,
    input wire cfg_s           i_cfg,
    input wire logic [NCH-1:0] o_txd,
    input wire logic [NCH-1:0] o_transmit_driver_enable,
    input wire logic           o_power_enable_n,
    input wire cfg_s           o_cfg
);
    logic [2:0]     rcnt_r;
    wire            ok  = rcnt_r > 3'h3;
    wire  [NCH-1:0] den = o_transmit_driver_enable;
    // Edges since release; the synced internal reset lags two edges
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            rcnt_r <= 3'h0;
        else if (rcnt_r != 3'h7)
            rcnt_r <= rcnt_r + 3'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_rst; rcnt_r < 3'h2 |-> o_txd == 2'h3 && den == 2'h0 && o_power_enable_n; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    property p_pwr; ok |-> o_power_enable_n == $past(i_suspend); endproperty
    a_pwr: assert property (p_pwr) else $error("power enable wrong");
    property p_idle; ok |-> (~o_txd & ~den) == 2'h0; endproperty
    a_idle: assert property (p_idle) else $error("line low without enable");
    property p_start; ok && $rose(den[1]) |-> !o_txd[1] [*8]; endproperty
    a_start: assert property (p_start) else $error("no start bit at enable");
    property p_fall; ok && $fell(den[1]) |-> $past(o_txd[1]) && o_txd[1]; endproperty
    a_fall: assert property (p_fall) else $error("enable fell before stop");
    property p_dflt; ok && !i_cfg_valid |-> o_cfg == CFG_DEFAULT; endproperty
    a_dflt: assert property (p_dflt) else $error("default config wrong");
    property p_adopt; ok && i_cfg_valid |-> o_cfg == i_cfg; endproperty
    a_adopt: assert property (p_adopt) else $error("config not adopted");
    property p_mode; ok && o_cfg.modes[3:2] != 2'h0 |-> o_txd[1] && !den[1]; endproperty
    a_mode: assert property (p_mode) else $error("non-serial channel sent");
endmodule
bind dual_uart_bridge dual_uart_props u_props (
    .i_clk, .i_rstn, .i_suspend, .i_cfg_valid, .i_cfg, .o_txd,
    .o_transmit_driver_enable, .o_power_enable_n, .o_cfg
);

// file: verif/serial_peer.sv
// Line model: channel 1 line heard by channel 0 receiver; channel 1 receiver held high
`timescale 1ns/10ps
module serial_peer (
    input  wire logic [1:0] i_txd,
    input  wire logic [1:0] i_den,
    output logic      [1:0] o_rxd
);
    assign o_rxd[0] = i_txd[1];
    assign o_rxd[1] = i_txd[1] | i_den[1];
endmodule

// file: verif/tb_dual_uart_bridge.sv
// Self-checking bench for the dual serial channel block
`timescale 1ns/10ps
module tb_dual_uart_bridge;
    import dual_uart_pkg::*;
    logic        i_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, i_suspend, i_cfg_valid;
    logic [7:0]  i_wb_adr, tx_byte;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat;
    logic        o_wb_ack, o_power_enable_n;
    logic [1:0]  i_rxd, o_txd, o_transmit_driver_enable;
    cfg_s        i_cfg, o_cfg;
    logic [63:0] expq[$];
    logic [63:0] q;
    int          n_mismatch, num_checks, t;
    dual_uart_bridge u_dual_uart_bridge (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
        .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_rxd, .o_txd,
        .o_transmit_driver_enable, .i_suspend, .o_power_enable_n, .i_cfg_valid, .i_cfg, .o_cfg);
    serial_peer u_serial_peer (.i_txd(o_txd), .i_den(o_transmit_driver_enable), .o_rxd(i_rxd));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) i_suspend <= 1'($urandom);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic over(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    // Classic cycle; a read notes its masked expectation first
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e);
        int k;
        if (!we)
            expq.push_back({m, e & m});
        @(posedge i_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'h3, we, a, d, 4'hf};
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 64);
        over(k, 64);
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    task automatic wait_den(input logic v, output int k);
        k = 0;
        while (o_transmit_driver_enable[1] !== v && k < 4000) begin
            @(posedge i_clk);
            k++;
        end
        over(k, 4000);
    endtask
    always @(posedge i_clk) begin
        if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && expq.size() > 0) begin
            q = expq.pop_front();
            chk("read data", o_wb_dat & q[63:32], q[31:0]);
        end
    end
    initial begin
        {i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, i_cfg_valid, i_suspend} = 6'h0;
        {i_wb_adr, i_wb_sel, i_wb_dat, i_cfg} = '0;
        n_mismatch = 0;
        num_checks = 0;
        tx_byte = 8'($urandom(32'h80339d60));
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        wb(0, 8'h40, 0, '1, {VENDOR_ID_DEF, PRODUCT_ID_DEF});
        wb(0, 8'h80, 0, '1, 32'h0);
        wb(0, 8'h04, 0, '1, 32'({DIV_FRAC_RST, DIV_INT_RST}));
        wb(0, 8'h44, 0, 32'h3fe, 32'h0);
        $display("test defaults done");
        wb(1, 8'h20, 32'h10, 0, 0);
        wb(0, 8'h20, 0, '1, 32'h10);
        wb(0, 8'h00, 0, '1, 32'h0);
        wb(1, 8'h20, 32'h0, 0, 0);
        // Divisor 4: 30 MHz tick, 160 ticks a frame, about 667 clocks
        wb(1, 8'h04, 32'h4, 0, 0);
        wb(1, 8'h24, 32'h4, 0, 0);
        wb(1, 8'h2c, {24'h0, tx_byte}, 0, 0);
        wait_den(1'b1, t);
        wait_den(1'b0, t);
        chk("frame time", 32'(t > 640 && t < 700), 32'h1);
        repeat (20) @(posedge i_clk);
        wb(0, 8'h0c, 0, 32'h1ff, {23'h0, 1'b1, tx_byte});
        wb(0, 8'h0c, 0, 32'h100, 32'h0);
        wb(0, 8'h2c, 0, 32'h100, 32'h0);
        // Seven bits, even parity, two stops, x10: 110 ticks, about 458 clocks
        wb(1, 8'h00, 32'h17, 0, 0);
        wb(1, 8'h20, 32'h17, 0, 0);
        wb(1, 8'h2c, {24'h0, tx_byte}, 0, 0);
        wait_den(1'b1, t);
        wait_den(1'b0, t);
        chk("short frame time", 32'(t > 440 && t < 480), 32'h1);
        repeat (20) @(posedge i_clk);
        wb(0, 8'h0c, 0, 32'h1ff, {24'h1, 1'b0, tx_byte[6:0]});
        wb(0, 8'h08, 0, 32'h1c000000, 32'h0);
        $display("test loopback done");
        i_rstn <= 1'b0;
        i_cfg_valid <= 1'b1;
        i_cfg <= cfg_s'(8'h04);
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        wb(0, 8'h44, 0, 32'h3fe, 32'h12);
        wb(1, 8'h2c, 32'h5a, 0, 0);
        repeat (200) @(posedge i_clk);
        wb(0, 8'h28, 0, 32'hc0000000, 32'h40000000);
        $display("test config done");
        complete_run();
    end
endmodule
